// >>> include/lamp_pkg.sv
package lamp_pkg;
	// system clock
	localparam int unsigned CLK_HZ         = 50_000_000;
	// lamp timing base: one tick every 10 ms
	localparam int unsigned TICK_MS        = 10;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	// pattern periods and on-times, in ticks
	localparam logic [7:0] SHORT_ON_TICKS  = 8'h05;   // 50 ms pulse
	localparam logic [7:0] FLASH_PERIOD    = 8'h32;   // 500 ms
	localparam logic [7:0] FLASH_ON        = 8'h0a;   // 100 ms
	localparam logic [7:0] BLINK_PERIOD    = 8'h28;   // 400 ms, 50 % duty
	localparam logic [7:0] BLINK_ON        = 8'h14;
	localparam logic [7:0] SLOW_PERIOD     = 8'h64;   // 1 s
	localparam logic [7:0] SLOW_ON         = 8'h32;   // 1 Hz slow blink
	localparam logic [7:0] SFLASH_ON       = 8'h0f;   // slow flash: 150 ms of 1 s
	localparam logic [7:0] RARE_PERIOD     = 8'hfa;   // 2.5 s no-link heartbeat
	localparam logic [7:0] RARE_ON         = 8'h0a;
	localparam logic [7:0] RUN_STEP        = 8'h0f;   // running light step
	// fault code group: flash slots then a gap
	localparam logic [7:0] CODE_SLOT       = 8'h1e;   // 300 ms per flash slot
	localparam logic [7:0] CODE_ON         = 8'h0f;
	localparam logic [3:0] CODE_GAP_SLOTS  = 4'h4;
	// fault code counts
	localparam logic [2:0] CODE_OVERRUN    = 3'h1;
	localparam logic [2:0] CODE_CONFIG     = 3'h3;
	localparam logic [2:0] CODE_DISK       = 3'h4;
	localparam logic [2:0] CODE_INTERNAL   = 3'h5;
endpackage

// >>> verilog/lamp_pulse.sv
`timescale 1ns/100ps
// stretches a one-cycle event into a visible lamp pulse of fixed length
module lamp_pulse (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic tick,
	input  wire logic event_in,
	output logic      pulse
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	// retrigger restarts the pulse so steady traffic keeps the lamp lit
	always_comb begin
		cnt_d = cnt_q;
		if (event_in) begin
			cnt_d = lamp_pkg::SHORT_ON_TICKS;
		end else if (tick && cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign pulse = (cnt_q != 8'h00);
endmodule

// >>> verilog/logger_status_lamp_driver.sv
`timescale 1ns/100ps
// Summary of operation
// - short yellow flash for each received CAN message.
// - error passive blinks yellow and red together.
// - bus off slow-flashes yellow and red together.
// - short amber flash for each received error frame.
// - green blinks at 1 Hz during autobaud, steady while logging.
// - logging starts only after autobaud completes.
// - live-interface use flashes green and holds red on.
// - amber steady while either ring buffer is overwritten.
// - CAN overrun is red on plus repeated single yellow flash; code two unused.
// - red on with yellow groups of three, four, five for config, disk, internal.
// - configuration mode runs a light around all four lamps.
// - disk maintenance blinks a lamp.
// - no USB link flashes green once every few seconds.
// - firmware configuration error flashes green and holds red on.
// - logger mode only when powered from the CAN side.
// - a full ring buffer wraps and overwrites, driving amber steady.
module logger_status_lamp_driver (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic can_rx_event,
	input  wire logic error_frame_event,
	input  wire logic error_passive,
	input  wire logic bus_off,
	input  wire logic autobaud_running,
	input  wire logic autobaud_done,
	input  wire logic can_powered,
	input  wire logic usb_powered,
	input  wire logic host_live_use,
	input  wire logic ring_overwrite,
	input  wire logic fault_overrun,
	input  wire logic fault_config_file,
	input  wire logic fault_disk,
	input  wire logic fault_internal,
	input  wire logic tool_config_mode,
	input  wire logic disk_maintenance,
	input  wire logic usb_link_up,
	input  wire logic firmware_config_error,
	output logic      logger_mode,
	output logic      log_enable,
	output logic      power_status_lamp,
	output logic      channel_lamp,
	output logic      error_frame_lamp,
	output logic      fault_lamp
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int unsigned NLEV = 16;
	logic [NLEV-1:0] lev_raw;
	logic [NLEV-1:0] sync1_q;
	logic [NLEV-1:0] sync2_q;
	logic [NLEV-1:0] sync1_d;
	logic [NLEV-1:0] sync2_d;
	logic [NLEV-1:0] lev;

	assign lev_raw = {can_rx_event, error_frame_event, error_passive, bus_off,
		autobaud_running, autobaud_done, can_powered, usb_powered,
		host_live_use, ring_overwrite, fault_overrun, fault_config_file,
		fault_disk, fault_internal, tool_config_mode, disk_maintenance};

	// events are pulses from firmware; only rising edges taken after sync
	always_comb begin
		sync1_d = lev_raw;
		sync2_d = sync1_q;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	assign lev = sync2_q;

	logic rx_l, ef_l, epas, boff, ab_run, ab_done, pwr_can, pwr_usb;
	logic live, ovw, f_ovr, f_cfg, f_disk, f_int, cfg_mode, maint;
	assign {rx_l, ef_l, epas, boff, ab_run, ab_done, pwr_can, pwr_usb,
		live, ovw, f_ovr, f_cfg, f_disk, f_int, cfg_mode, maint} = lev;

	logic link_s1_q, link_s2_q, fwerr_s1_q, fwerr_s2_q;
	logic rx_prev_q, ef_prev_q;

	// ------------------------------------------------------------
	// prescaler and pattern timers
	// ------------------------------------------------------------
	logic [19:0] pre_q;
	logic [19:0] pre_d;
	logic        tick;
	logic [7:0]  ph_q;
	logic [7:0]  ph_d;
	logic [7:0]  rare_q;
	logic [7:0]  rare_d;
	logic [7:0]  slot_q;
	logic [7:0]  slot_d;
	logic [3:0]  slot_idx_q;
	logic [3:0]  slot_idx_d;
	logic [1:0]  run_q;
	logic [1:0]  run_d;
	logic [7:0]  run_t_q;
	logic [7:0]  run_t_d;
	logic [2:0]  code;

	assign tick = (pre_q == 20'(lamp_pkg::TICK_CYCLES - 1));

	always_comb begin
		pre_d      = tick ? 20'h00000 : pre_q + 20'h00001;
		ph_d       = ph_q;
		rare_d     = rare_q;
		slot_d     = slot_q;
		slot_idx_d = slot_idx_q;
		run_d      = run_q;
		run_t_d    = run_t_q;
		if (tick) begin
			// shared phase wraps at 2 s, a multiple of every short period
			ph_d   = (ph_q == 8'hc7) ? 8'h00 : ph_q + 8'h01;
			rare_d = (rare_q == lamp_pkg::RARE_PERIOD - 8'h01) ? 8'h00 : rare_q + 8'h01;
			if (slot_q == lamp_pkg::CODE_SLOT - 8'h01) begin
				slot_d = 8'h00;
				slot_idx_d = (slot_idx_q == 4'(code) + lamp_pkg::CODE_GAP_SLOTS - 4'h1) ?
					4'h0 : slot_idx_q + 4'h1;
			end else begin
				slot_d = slot_q + 8'h01;
			end
			if (run_t_q == lamp_pkg::RUN_STEP - 8'h01) begin
				run_t_d = 8'h00;
				run_d   = run_q + 2'h1;
			end else begin
				run_t_d = run_t_q + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// fault code selection
	// ------------------------------------------------------------
	// overrun uses one flash; two never selected
	always_comb begin
		if (f_int) begin
			code = lamp_pkg::CODE_INTERNAL;
		end else if (f_disk) begin
			code = lamp_pkg::CODE_DISK;
		end else if (f_cfg) begin
			code = lamp_pkg::CODE_CONFIG;
		end else if (f_ovr) begin
			code = lamp_pkg::CODE_OVERRUN;
		end else begin
			code = 3'h0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pre_q      <= 20'h00000;
			ph_q       <= 8'h00;
			rare_q     <= 8'h00;
			slot_q     <= 8'h00;
			slot_idx_q <= 4'h0;
			run_q      <= 2'h0;
			run_t_q    <= 8'h00;
			link_s1_q  <= 1'b0;
			link_s2_q  <= 1'b0;
			fwerr_s1_q <= 1'b0;
			fwerr_s2_q <= 1'b0;
			rx_prev_q  <= 1'b0;
			ef_prev_q  <= 1'b0;
		end else begin
			pre_q      <= pre_d;
			ph_q       <= ph_d;
			rare_q     <= rare_d;
			slot_q     <= slot_d;
			slot_idx_q <= slot_idx_d;
			run_q      <= run_d;
			run_t_q    <= run_t_d;
			link_s1_q  <= usb_link_up;
			link_s2_q  <= link_s1_q;
			fwerr_s1_q <= firmware_config_error;
			fwerr_s2_q <= fwerr_s1_q;
			rx_prev_q  <= rx_l;
			ef_prev_q  <= ef_l;
		end
	end

	// ------------------------------------------------------------
	// pattern waveforms
	// ------------------------------------------------------------
	logic p_flash, p_blink, p_slow, p_sflash, p_rare, p_code;
	logic rx_pulse, ef_pulse;

	assign p_flash  = ((ph_q % lamp_pkg::FLASH_PERIOD) < lamp_pkg::FLASH_ON);
	assign p_blink  = ((ph_q % lamp_pkg::BLINK_PERIOD) < lamp_pkg::BLINK_ON);
	assign p_slow   = ((ph_q % lamp_pkg::SLOW_PERIOD) < lamp_pkg::SLOW_ON);
	assign p_sflash = ((ph_q % lamp_pkg::SLOW_PERIOD) < lamp_pkg::SFLASH_ON);
	assign p_rare   = (rare_q < lamp_pkg::RARE_ON);
	assign p_code   = (slot_idx_q < 4'(code)) && (slot_q < lamp_pkg::CODE_ON);

	lamp_pulse u_rx_pulse (
		.core_clk (core_clk),
		.reset    (reset),
		.tick     (tick),
		.event_in (rx_l & ~rx_prev_q),
		.pulse    (rx_pulse)
	);

	lamp_pulse u_ef_pulse (
		.core_clk (core_clk),
		.reset    (reset),
		.tick     (tick),
		.event_in (ef_l & ~ef_prev_q),
		.pulse    (ef_pulse)
	);

	// ------------------------------------------------------------
	// mode gating and lamp selection
	// ------------------------------------------------------------
	logic mode_d, log_d, g_d, y_d, a_d, r_d;
	logic mode_q, log_q, g_q, y_q, a_q, r_q;

	always_comb begin
		mode_d = pwr_can & ~cfg_mode;
		log_d  = mode_d & ab_done & ~ab_run;
	end

	always_comb begin
		g_d = 1'b0;
		y_d = 1'b0;
		a_d = 1'b0;
		r_d = 1'b0;
		if (cfg_mode) begin
			g_d = (run_q == 2'h0);
			y_d = (run_q == 2'h1);
			a_d = (run_q == 2'h2);
			r_d = (run_q == 2'h3);
		end else if (maint) begin
			r_d = p_blink;
		end else if (fwerr_s2_q || live) begin
			g_d = p_flash;
			r_d = 1'b1;
		end else if (code != 3'h0) begin
			r_d = 1'b1;
			y_d = p_code;
			a_d = ovw;
		end else if (!link_s2_q && pwr_usb && !pwr_can) begin
			g_d = p_rare;
			// overwrite stays visible on USB supply too
			a_d = ovw;
		end else begin
			g_d = ab_run ? p_slow : log_d;
			if (boff) begin
				y_d = p_sflash;
				r_d = p_sflash;
			end else if (epas) begin
				y_d = p_blink;
				r_d = p_blink;
			end else begin
				y_d = rx_pulse;
			end
			a_d = ovw | ef_pulse;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_q <= 1'b0;
			log_q  <= 1'b0;
			g_q    <= 1'b0;
			y_q    <= 1'b0;
			a_q    <= 1'b0;
			r_q    <= 1'b0;
		end else begin
			mode_q <= mode_d;
			log_q  <= log_d;
			g_q    <= g_d;
			y_q    <= y_d;
			a_q    <= a_d;
			r_q    <= r_d;
		end
	end

	assign logger_mode       = mode_q;
	assign log_enable        = log_q;
	assign power_status_lamp = g_q;
	assign channel_lamp      = y_q;
	assign error_frame_lamp  = a_q;
	assign fault_lamp        = r_q;
endmodule

// >>> testbench/lamp_driver_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// lamp driver checker
// ----------------------------------------
module lamp_driver_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic can_rx_event,
	input wire logic error_frame_event,
	input wire logic error_passive,
	input wire logic bus_off,
	input wire logic autobaud_running,
	input wire logic autobaud_done,
	input wire logic can_powered,
	input wire logic host_live_use,
	input wire logic ring_overwrite,
	input wire logic fault_overrun,
	input wire logic fault_config_file,
	input wire logic fault_disk,
	input wire logic fault_internal,
	input wire logic tool_config_mode,
	input wire logic disk_maintenance,
	input wire logic firmware_config_error,
	input wire logic logger_mode,
	input wire logic log_enable,
	input wire logic power_status_lamp,
	input wire logic channel_lamp,
	input wire logic error_frame_lamp,
	input wire logic fault_lamp
);
	logic [2:0] age_q;
	logic [2:0] age_d;
	logic       ready;
	logic       top_req;
	logic       red_req;
	logic       quiet;
	// age since reset: the synchronisers still hold reset values early on
	always_comb begin
		age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			age_q <= 3'h0;
		end else begin
			age_q <= age_d;
		end
	end
	// mode groups, highest priority first
	assign ready   = (age_q == 3'h7);
	assign top_req = tool_config_mode | disk_maintenance;
	assign red_req = firmware_config_error | host_live_use | fault_overrun | fault_config_file | fault_disk | fault_internal;
	assign quiet   = ready & can_powered & ~top_req & ~red_req & ~error_passive & ~bus_off;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// causes held long enough to pass the three-cycle input path
	sequence red_held; (ready & ~top_req & red_req) [*4]; endsequence
	sequence ring_held; (ready & ~top_req & ~host_live_use & ~firmware_config_error & ring_overwrite) [*4]; endsequence
	sequence log_held; (quiet & log_enable) [*4]; endsequence
	a_reset_dark: assert property ($past(reset) |-> !(logger_mode | log_enable | power_status_lamp | channel_lamp
		| error_frame_lamp | fault_lamp)) else $error("outputs lit right after reset");
	a_mode_gate: assert property (ready |-> logger_mode == $past(can_powered & ~tool_config_mode, 3))
		else $error("logger mode not gated by power source");
	a_log_start: assert property (ready |->
		log_enable == $past(can_powered & ~tool_config_mode & autobaud_done & ~autobaud_running, 3))
		else $error("logging start wrong");
	a_rx_flash: assert property ($rose(can_rx_event) && quiet |-> ##[2:4] channel_lamp)
		else $error("no channel flash on message");
	a_err_flash: assert property ($rose(error_frame_event) && quiet |-> ##[2:4] error_frame_lamp)
		else $error("no amber flash on error frame");
	a_red_steady: assert property (red_held |-> fault_lamp) else $error("red not steady on fault");
	a_ring_amber: assert property (ring_held |-> error_frame_lamp) else $error("amber not steady on overwrite");
	a_log_green: assert property (log_held |-> power_status_lamp) else $error("green not steady while logging");
	a_quiet_red: assert property (quiet [*4] |-> !fault_lamp) else $error("red lit without cause");
endmodule

// >>> testbench/can_traffic_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// can traffic source: one request gives one rising edge on the event line
// ----------------------------------------
module can_traffic_src (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic send_rx,
	input  wire logic send_err,
	output logic      can_rx_event,
	output logic      error_frame_event
);
	logic [1:0] evt_q;
	logic [1:0] evt_d;
	// a one-cycle level is enough, the driver samples every edge
	always_comb begin
		evt_d = {send_rx, send_err};
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			evt_q <= 2'h0;
		end else begin
			evt_q <= evt_d;
		end
	end
	assign can_rx_event      = evt_q[1];
	assign error_frame_event = evt_q[0];
endmodule

// >>> testbench/test_logger_status_lamp_driver.sv
`timescale 1ns/100ps
module test_logger_status_lamp_driver;
	logic        core_clk;
	logic        reset;
	logic        send_rx;
	logic        send_err;
	logic        can_rx_event;
	logic        error_frame_event;
	logic [15:0] stim;
	logic        logger_mode;
	logic        log_enable;
	logic        power_status_lamp;
	logic        channel_lamp;
	logic        error_frame_lamp;
	logic        fault_lamp;
	logic [4:0]  row_seen;
	int          num_errors;
	int          check_count;
	// ----------------------------------------
	// rows: inputs, expected {mode,log,green,amber,red}, care mask
	// ----------------------------------------
	localparam logic [25:0] ROWS [16] = '{
		{16'h9001, 5'h1c, 5'h1f}, {16'h9801, 5'h14, 5'h1f}, {16'h5001, 5'h00, 5'h1f}, {16'hb001, 5'h04, 5'h1f},
		{16'h9401, 5'h1e, 5'h1f}, {16'h9201, 5'h19, 5'h1f}, {16'h9101, 5'h19, 5'h1f}, {16'h9081, 5'h19, 5'h1f},
		{16'h9041, 5'h19, 5'h1f}, {16'h9021, 5'h1d, 5'h1f}, {16'h9011, 5'h1d, 5'h1f}, {16'h9481, 5'h1b, 5'h1f},
		{16'h9009, 5'h1d, 5'h1f}, {16'h9005, 5'h1d, 5'h1f}, {16'h9003, 5'h19, 5'h1f}, {16'h4000, 5'h04, 5'h1f}};
	// every pattern starts in its lit phase, so ten cycles after reset each lamp shows its on level
	assign row_seen = {logger_mode, log_enable, power_status_lamp, error_frame_lamp, fault_lamp};
	can_traffic_src i_src (.core_clk(core_clk), .reset(reset), .send_rx(send_rx), .send_err(send_err),
		.can_rx_event(can_rx_event), .error_frame_event(error_frame_event));
	logger_status_lamp_driver i_dut (.core_clk(core_clk), .reset(reset), .can_rx_event(can_rx_event),
		.error_frame_event(error_frame_event), .can_powered(stim[15]), .usb_powered(stim[14]),
		.tool_config_mode(stim[13]), .autobaud_done(stim[12]), .autobaud_running(stim[11]),
		.ring_overwrite(stim[10]), .fault_overrun(stim[9]), .fault_config_file(stim[8]), .fault_disk(stim[7]),
		.fault_internal(stim[6]), .firmware_config_error(stim[5]), .host_live_use(stim[4]),
		.error_passive(stim[3]), .bus_off(stim[2]), .disk_maintenance(stim[1]), .usb_link_up(stim[0]),
		.logger_mode(logger_mode), .log_enable(log_enable), .power_status_lamp(power_status_lamp),
		.channel_lamp(channel_lamp), .error_frame_lamp(error_frame_lamp), .fault_lamp(fault_lamp));
	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic check_bits(input string what, input logic [4:0] exp, input logic [4:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// fresh reset per row so earlier pulses cannot leak into the next row
	task automatic run_row(input logic [15:0] v);
		@(posedge core_clk);
		reset <= 1'b1;
		stim  <= v;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
	endtask
	task automatic summarize();
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		stim = 16'h0000;
		send_rx = 1'b0;
		send_err = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 16; i++) begin
			run_row(ROWS[i][25:10]);
			check_bits($sformatf("row %0d", i), ROWS[i][9:5], row_seen & ROWS[i][4:0]);
		end
		// both event lamps together, then a reset while they are lit
		run_row(16'h9001);
		check_bits("lamps idle", 5'h00, {3'h0, channel_lamp, error_frame_lamp});
		@(posedge core_clk);
		send_rx <= 1'b1;
		send_err <= 1'b1;
		@(posedge core_clk);
		send_rx <= 1'b0;
		send_err <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		check_bits("event lamps", 5'h03, {3'h0, channel_lamp, error_frame_lamp});
		@(posedge core_clk);
		reset <= 1'b1;
		@(posedge core_clk);
		#1;
		check_bits("reset lamps", 5'h00, {1'b0, power_status_lamp, channel_lamp, error_frame_lamp, fault_lamp});
		summarize();
	end
	// watchdog well beyond the roughly 230 cycles of tests
	initial begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		summarize();
	end
endmodule
bind logger_status_lamp_driver lamp_driver_chk i_chk (.core_clk, .reset, .can_rx_event, .error_frame_event,
	.error_passive, .bus_off, .autobaud_running, .autobaud_done, .can_powered, .host_live_use, .ring_overwrite,
	.fault_overrun, .fault_config_file, .fault_disk, .fault_internal, .tool_config_mode, .disk_maintenance,
	.firmware_config_error, .logger_mode, .log_enable, .power_status_lamp, .channel_lamp, .error_frame_lamp,
	.fault_lamp);
